// File: char_lcd_pkg.sv
// Shared constants and types for the character display instruction decoder
package char_lcd_pkg;

   // Timing
   localparam longint CLK_PERIOD_PS   = 64'd4000;
   localparam longint EXEC_SHORT_NS   = 64'd38000;
   localparam longint EXEC_LONG_NS    = 64'd1520000;
   localparam longint BLINK_HALF_MS   = 64'd400;
   localparam int     EXEC_SHORT_CYC  = int'((EXEC_SHORT_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1)
                                             / CLK_PERIOD_PS);
   localparam int     EXEC_LONG_CYC   = int'((EXEC_LONG_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1)
                                             / CLK_PERIOD_PS);
   localparam int     BLINK_HALF_CYC  = int'((BLINK_HALF_MS * 64'd1000000000) / CLK_PERIOD_PS);

   // Address spaces
   localparam int       CHAR_DEPTH    = 128;
   localparam int       GLYPH_DEPTH   = 64;
   localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
   localparam logic [6:0] ROW0_LAST     = 7'h27;
   localparam logic [6:0] ROW1_FIRST    = 7'h40;
   localparam logic [6:0] ROW1_LAST     = 7'h67;
   localparam logic [6:0] SHIFT_LIM_1L  = 7'h4f;
   localparam logic [6:0] SHIFT_LIM_2L  = 7'h27;
   localparam logic [7:0] SPACE_CODE    = 8'h20;

   // Operand bit positions
   localparam int BIT_ENTRY_INC  = 1;
   localparam int BIT_ENTRY_SCR  = 0;
   localparam int BIT_DISP_ON    = 2;
   localparam int BIT_CURS_ON    = 1;
   localparam int BIT_BLINK_ON   = 0;
   localparam int BIT_SHIFT_DISP = 3;
   localparam int BIT_SHIFT_RGT  = 2;
   localparam int BIT_FUNC_BUS8  = 4;
   localparam int BIT_FUNC_2LINE = 3;
   localparam int BIT_FUNC_TALL  = 2;

   // Cursor dot row per font
   localparam logic [3:0] CURSOR_ROW_SHORT = 4'h7;
   localparam logic [3:0] CURSOR_ROW_TALL  = 4'ha;

   // Reset values
   localparam logic RST_BUS8 = 1'b1;
   localparam logic RST_INC  = 1'b1;

   typedef enum {
      INS_NONE, INS_CLEAR, INS_HOME, INS_ENTRY, INS_ONOFF,
      INS_SHIFT, INS_FUNC, INS_GLYPH_ADDR, INS_CHAR_ADDR
   } instr_t;

   typedef enum { ST_IDLE, ST_BUSY } exec_state_t;

   typedef struct packed {
      logic display_on;
      logic cursor_on;
      logic blink_on;
      logic two_line;
      logic font_tall;
   } disp_cfg_t;

endpackage

// File: addr_stepper.sv
// Next address counter value for one step with row and space wrap
`timescale 1ns/1ps
module addr_stepper
   import char_lcd_pkg::*;
(
   input  wire logic [6:0] addr_i,
   input  wire logic       dec_i,
   input  wire logic       glyph_i,
   input  wire logic       two_line_i,
   output logic      [6:0] addr_o
);
   always_comb begin
      addr_o = dec_i ? addr_i - 7'd1 : addr_i + 7'd1;
      if (glyph_i) begin
         addr_o = {1'b0, addr_o[5:0]};
      end else if (!two_line_i) begin
         if (!dec_i && addr_i == ONE_LINE_LAST) addr_o = 7'h00;
         if (dec_i && addr_i == 7'h00) addr_o = ONE_LINE_LAST;
      end else begin
         if (!dec_i && addr_i == ROW0_LAST) addr_o = ROW1_FIRST;
         if (!dec_i && addr_i == ROW1_LAST) addr_o = 7'h00;
         if (dec_i && addr_i == 7'h00) addr_o = ROW1_LAST;
         if (dec_i && addr_i == ROW1_FIRST) addr_o = ROW0_LAST;
      end
   end
endmodule // addr_stepper

// File: char_lcd_instruction_decoder.sv
// Instruction decoder, address counter and display RAMs of a character display controller
`timescale 1ns/1ps
module char_lcd_instruction_decoder
   import char_lcd_pkg::*;
#(
   parameter int SHORT_CYC = EXEC_SHORT_CYC,
   parameter int LONG_CYC  = EXEC_LONG_CYC,
   parameter int BLINK_CYC = BLINK_HALF_CYC
)(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       xfer_i,
   input  wire logic       cmd_data_select_i,
   input  wire logic       read_i,
   input  wire logic [7:0] bus_data_i,
   input  wire logic [6:0] disp_addr_i,
   input  wire logic [5:0] glyph_addr_i,
   output logic      [7:0] bus_data_o,
   output logic            busy_flag_o,
   output logic            bus_width_select_o,
   output disp_cfg_t       disp_cfg_o,
   output logic      [6:0] disp_shift_o,
   output logic      [6:0] cursor_addr_o,
   output logic      [3:0] cursor_row_o,
   output logic            blink_phase_o,
   output logic      [7:0] disp_char_o,
   output logic      [7:0] glyph_row_o
);
   localparam int CW = $clog2(LONG_CYC + 1);
   localparam int BW = $clog2(BLINK_CYC + 1);

   // Refuse timing values the counters cannot serve
   if (SHORT_CYC < 1 || SHORT_CYC > LONG_CYC || LONG_CYC <= CHAR_DEPTH
       || BLINK_CYC < 1) begin : g_bad_timing
      $error("char_lcd_instruction_decoder: timing parameters out of range");
   end

   logic [7:0]  char_ram  [CHAR_DEPTH];
   logic [7:0]  glyph_ram [GLYPH_DEPTH];

   exec_state_t state_ff;
   logic [CW-1:0] cnt_ff;
   logic        bus8_ff;
   logic        nib_hi_ff;
   logic [3:0]  nib_ff;
   logic        inc_ff;
   logic        scroll_ff;
   logic        glyph_tgt_ff;
   disp_cfg_t   cfg_ff;
   logic [6:0]  addr_cnt_ff;
   logic [6:0]  shift_ff;
   logic        step_pend_ff;
   logic        step_dec_ff;
   logic        reload_ff;
   logic [7:0]  latch_ff;
   logic [7:0]  rd_byte_ff;
   logic        clr_run_ff;
   logic [6:0]  clr_idx_ff;
   logic [BW-1:0] blink_cnt_ff;
   logic        blink_ff;
   logic [7:0]  bus_out_ff;

   logic        act_wr;
   logic        act_rd;
   logic [7:0]  byte_val;
   logic        cmd_wr;
   logic        data_wr;
   logic        data_rd;
   logic        stat_rd;
   logic        exec_done;
   instr_t      instr;
   logic [6:0]  addr_next;
   logic [6:0]  shift_lim;

   // Transfer assembly: writes act on the last nibble, reads on the first
   always_comb begin
      act_wr   = xfer_i && !read_i && (bus8_ff || nib_hi_ff);
      act_rd   = xfer_i && read_i && (bus8_ff || !nib_hi_ff);
      byte_val = bus8_ff ? bus_data_i : {nib_ff, bus_data_i[7:4]};
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         nib_hi_ff <= 1'b0;
         nib_ff    <= 4'h0;
      end else if (xfer_i && !bus8_ff) begin
         nib_hi_ff <= !nib_hi_ff;
         nib_ff    <= bus_data_i[7:4];
      end else if (bus8_ff) begin
         nib_hi_ff <= 1'b0;
      end
   end

   // Busy refuses all but status reads
   always_comb begin
      cmd_wr    = act_wr && !cmd_data_select_i && state_ff == ST_IDLE;
      data_wr   = act_wr && cmd_data_select_i && state_ff == ST_IDLE;
      data_rd   = act_rd && cmd_data_select_i && state_ff == ST_IDLE;
      stat_rd   = act_rd && !cmd_data_select_i;
      exec_done = state_ff == ST_BUSY && cnt_ff == '0;
   end

   // Highest set line picks the instruction
   always_comb begin
      casez (byte_val)
         8'b1???????: instr = INS_CHAR_ADDR;
         8'b01??????: instr = INS_GLYPH_ADDR;
         8'b001?????: instr = INS_FUNC;
         8'b0001????: instr = INS_SHIFT;
         8'b00001???: instr = INS_ONOFF;
         8'b000001??: instr = INS_ENTRY;
         8'b0000001?: instr = INS_HOME;
         8'b00000001: instr = INS_CLEAR;
         default:     instr = INS_NONE;
      endcase
   end

   // Execution timer and busy flag
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if ((cmd_wr && instr != INS_NONE) || data_wr || data_rd) begin
                  state_ff <= ST_BUSY;
                  if (cmd_wr && (instr == INS_CLEAR || instr == INS_HOME))
                     cnt_ff <= CW'(LONG_CYC - 1);
                  else
                     cnt_ff <= CW'(SHORT_CYC - 1);
               end
            end
            ST_BUSY: begin
               if (exec_done) state_ff <= ST_IDLE;
               else cnt_ff <= cnt_ff - 1'b1;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Mode and configuration bits
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         bus8_ff   <= RST_BUS8;
         inc_ff    <= RST_INC;
         scroll_ff <= 1'b0;
         cfg_ff    <= '0;
      end else if (cmd_wr) begin
         case (instr)
            INS_CLEAR: inc_ff <= 1'b1;
            INS_ENTRY: begin
               inc_ff    <= byte_val[BIT_ENTRY_INC];
               scroll_ff <= byte_val[BIT_ENTRY_SCR];
            end
            INS_ONOFF: begin
               cfg_ff.display_on <= byte_val[BIT_DISP_ON];
               cfg_ff.cursor_on  <= byte_val[BIT_CURS_ON];
               cfg_ff.blink_on   <= byte_val[BIT_BLINK_ON];
            end
            INS_FUNC: begin
               bus8_ff          <= byte_val[BIT_FUNC_BUS8];
               cfg_ff.two_line  <= byte_val[BIT_FUNC_2LINE];
               cfg_ff.font_tall <= byte_val[BIT_FUNC_TALL];
            end
            default: ;
         endcase
      end
   end

   addr_stepper u_step (
      .addr_i     (addr_cnt_ff),
      .dec_i      (step_dec_ff),
      .glyph_i    (glyph_tgt_ff),
      .two_line_i (cfg_ff.two_line),
      .addr_o     (addr_next)
   );

   // Address counter, target RAM and deferred step
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         addr_cnt_ff  <= 7'h00;
         glyph_tgt_ff <= 1'b0;
         step_pend_ff <= 1'b0;
         step_dec_ff  <= 1'b0;
         reload_ff    <= 1'b0;
      end else if (exec_done) begin
         if (step_pend_ff) addr_cnt_ff <= addr_next;
         step_pend_ff <= 1'b0;
         reload_ff    <= 1'b0;
      end else if (cmd_wr) begin
         case (instr)
            INS_CLEAR, INS_HOME: begin
               addr_cnt_ff  <= 7'h00;
               glyph_tgt_ff <= 1'b0;
            end
            INS_SHIFT: if (!byte_val[BIT_SHIFT_DISP]) begin
               step_pend_ff <= 1'b1;
               step_dec_ff  <= !byte_val[BIT_SHIFT_RGT];
               reload_ff    <= !glyph_tgt_ff;
            end
            INS_GLYPH_ADDR: begin
               addr_cnt_ff  <= {1'b0, byte_val[5:0]};
               glyph_tgt_ff <= 1'b1;
               reload_ff    <= 1'b1;
            end
            INS_CHAR_ADDR: begin
               addr_cnt_ff  <= byte_val[6:0];
               glyph_tgt_ff <= 1'b0;
               reload_ff    <= 1'b1;
            end
            default: ;
         endcase
      end else if (data_wr || data_rd) begin
         step_pend_ff <= 1'b1;
         step_dec_ff  <= !inc_ff;
         reload_ff    <= data_rd;
      end
   end

   // Display shift offset
   always_comb shift_lim = cfg_ff.two_line ? SHIFT_LIM_2L : SHIFT_LIM_1L;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         shift_ff <= 7'h00;
      end else if (cmd_wr && (instr == INS_CLEAR || instr == INS_HOME)) begin
         shift_ff <= 7'h00;
      end else if ((cmd_wr && instr == INS_SHIFT && byte_val[BIT_SHIFT_DISP])
                   || (data_wr && scroll_ff && !glyph_tgt_ff)) begin
         if (cmd_wr ? !byte_val[BIT_SHIFT_RGT] : inc_ff)
            shift_ff <= (shift_ff >= shift_lim) ? 7'h00 : shift_ff + 7'd1;
         else
            shift_ff <= (shift_ff == 7'h00) ? shift_lim : shift_ff - 7'd1;
      end
   end

   // RAM writes and clear fill
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         clr_run_ff <= 1'b0;
         clr_idx_ff <= 7'h00;
      end else if (cmd_wr && instr == INS_CLEAR) begin
         clr_run_ff <= 1'b1;
         clr_idx_ff <= 7'h00;
      end else if (clr_run_ff) begin
         clr_idx_ff <= clr_idx_ff + 7'd1;
         if (clr_idx_ff == 7'(CHAR_DEPTH - 1)) clr_run_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clr_run_ff)
         char_ram[clr_idx_ff] <= SPACE_CODE;
      else if (data_wr && !glyph_tgt_ff)
         char_ram[addr_cnt_ff] <= byte_val;
   end

   always_ff @(posedge core_clk_i) begin
      if (data_wr && glyph_tgt_ff) glyph_ram[addr_cnt_ff[5:0]] <= byte_val;
   end

   // Read latch: refreshed only after address set, cursor shift in character RAM, or read
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         latch_ff <= 8'h00;
      end else if (exec_done && reload_ff) begin
         if (glyph_tgt_ff)
            latch_ff <= glyph_ram[(step_pend_ff ? addr_next[5:0] : addr_cnt_ff[5:0])];
         else
            latch_ff <= char_ram[(step_pend_ff ? addr_next : addr_cnt_ff)];
      end
   end

   // Bus read data
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_byte_ff <= 8'h00;
         bus_out_ff <= 8'h00;
      end else if (act_rd) begin
         if (stat_rd)
            rd_byte_ff <= {state_ff == ST_BUSY, addr_cnt_ff};
         else if (data_rd)
            rd_byte_ff <= latch_ff;
         if (stat_rd)
            bus_out_ff <= bus8_ff ? {state_ff == ST_BUSY, addr_cnt_ff}
                                  : {state_ff == ST_BUSY, addr_cnt_ff[6:4], 4'h0};
         else if (data_rd)
            bus_out_ff <= bus8_ff ? latch_ff : {latch_ff[7:4], 4'h0};
      end else if (xfer_i && read_i && !bus8_ff) begin
         bus_out_ff <= {rd_byte_ff[3:0], 4'h0};
      end
   end

   // Blink timer
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !cfg_ff.blink_on) begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end else if (blink_cnt_ff == BW'(BLINK_CYC - 1)) begin
         blink_cnt_ff <= '0;
         blink_ff     <= !blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 1'b1;
      end
   end

   // Registered outputs toward the display driver
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         disp_char_o   <= 8'h00;
         glyph_row_o   <= 8'h00;
         cursor_row_o  <= CURSOR_ROW_SHORT;
      end else begin
         disp_char_o   <= char_ram[disp_addr_i];
         glyph_row_o   <= glyph_ram[glyph_addr_i];
         cursor_row_o  <= cfg_ff.font_tall ? CURSOR_ROW_TALL : CURSOR_ROW_SHORT;
      end
   end

   always_comb begin
      bus_data_o         = bus_out_ff;
      busy_flag_o        = state_ff == ST_BUSY;
      bus_width_select_o = bus8_ff;
      disp_cfg_o         = cfg_ff;
      disp_shift_o       = shift_ff;
      cursor_addr_o      = addr_cnt_ff;
      blink_phase_o      = blink_ff;
   end

endmodule // char_lcd_instruction_decoder

// File: char_lcd_instruction_decoder_properties.sv
// Port checks for the instruction decoder
`timescale 1ns/1ps
module char_lcd_instruction_decoder_properties
   import char_lcd_pkg::*;
#(
   parameter int SHORT_CYC = 4,
   parameter int LONG_CYC  = 200,
   parameter int BLINK_CYC = 8
)(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       xfer_i,
   input wire logic       cmd_data_select_i,
   input wire logic       read_i,
   input wire logic [7:0] bus_data_i,
   input wire logic [7:0] bus_data_o,
   input wire logic       busy_flag_o,
   input wire logic       bus_width_select_o,
   input wire disp_cfg_t  disp_cfg_o,
   input wire logic [6:0] disp_shift_o,
   input wire logic [6:0] cursor_addr_o,
   input wire logic [3:0] cursor_row_o,
   input wire logic       blink_phase_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   int   busy_cnt;
   int   run_cnt;
   logic last_ph;
   logic go;
   assign go = xfer_i && !busy_flag_o && bus_width_select_o;
   // Busy length
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !busy_flag_o) busy_cnt <= 0;
      else busy_cnt <= busy_cnt + 1;
   end
   // Blink phase run length
   always_ff @(posedge core_clk_i) begin
      last_ph <= blink_phase_o;
      if (rst_i || !disp_cfg_o.blink_on || blink_phase_o != last_ph) run_cnt <= 0;
      else run_cnt <= run_cnt + 1;
   end
   chk_busy_start: assert property (
      go && (cmd_data_select_i || (!read_i && bus_data_i != 8'h00)) |=> busy_flag_o)
      else $error("busy not raised");
   chk_busy_len: assert property (
      $fell(busy_flag_o) |-> (busy_cnt == SHORT_CYC || busy_cnt == LONG_CYC))
      else $error("busy length wrong");
   chk_status_read: assert property (
      xfer_i && read_i && !cmd_data_select_i && bus_width_select_o
      |=> bus_data_o == {$past(busy_flag_o), $past(cursor_addr_o)})
      else $error("status read wrong");
   chk_cfg_hold: assert property (
      busy_flag_o && $past(busy_flag_o) |-> $stable({disp_cfg_o, bus_width_select_o}))
      else $error("config changed while busy");
   chk_shift_keeps_addr: assert property (
      go && !cmd_data_select_i && !read_i && bus_data_i[7:3] == 5'b00011
      |=> $stable(cursor_addr_o)[*4])
      else $error("display shift moved counter");
   chk_home_zero: assert property (
      go && !cmd_data_select_i && !read_i && bus_data_i[7:2] == 6'h00
      && bus_data_i[1:0] != 2'b00
      |-> ##[1:400] (!busy_flag_o && cursor_addr_o == 7'h00 && disp_shift_o == 7'h00))
      else $error("home or clear did not zero");
   chk_blink_off: assert property (
      !disp_cfg_o.blink_on && !$past(disp_cfg_o.blink_on) |-> !blink_phase_o)
      else $error("blink phase while off");
   chk_blink_run: assert property (
      disp_cfg_o.blink_on |-> run_cnt <= BLINK_CYC + 1)
      else $error("blink phase stuck");
   chk_cursor_row: assert property (
      $stable(disp_cfg_o.font_tall)
      |-> cursor_row_o == (disp_cfg_o.font_tall ? 4'ha : 4'h7))
      else $error("cursor row wrong");
endmodule // char_lcd_instruction_decoder_properties

// File: host_port_model.sv
// Host processor model on the parallel instruction port
`timescale 1ns/1ps
module host_port_model (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] rd_data_i,
   output logic            xfer_o,
   output logic            cmd_data_select_o,
   output logic            read_o,
   output logic      [7:0] bus_data_o
);
   logic narrow = 1'b0;
   initial begin
      xfer_o = 1'b0;
      cmd_data_select_o = 1'b0;
      read_o = 1'b0;
      bus_data_o = 8'h00;
   end
   // One transfer, data lines scrambled once released
   task automatic pulse(input logic sel, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
      @(negedge core_clk_i);
      xfer_o = 1'b1;
      cmd_data_select_o = sel;
      read_o = rd;
      bus_data_o = d;
      @(negedge core_clk_i);
      xfer_o = 1'b0;
      bus_data_o = ~d;
      q = rd_data_i;
   endtask
   task automatic put(input logic sel, input logic rd, input logic [7:0] d,
                      output logic [7:0] q);
      logic [7:0] hi;
      logic [7:0] lo;
      if (narrow) begin
         pulse(sel, rd, {d[7:4], 4'h0}, hi);
         pulse(sel, rd, {d[3:0], 4'h0}, lo);
         q = {hi[7:4], lo[7:4]};
      end else pulse(sel, rd, d, q);
   endtask
   task automatic ready();
      logic [7:0] st;
      int         n;
      st = 8'h80;
      n = 0;
      while (st[7] && n < 600) begin
         put(1'b0, 1'b1, 8'h00, st);
         n++;
      end
   endtask
   task automatic send(input logic sel, input logic [7:0] d);
      logic [7:0] q;
      ready();
      put(sel, 1'b0, d, q);
   endtask
   task automatic get(input logic sel, output logic [7:0] q);
      ready();
      put(sel, 1'b1, 8'h00, q);
   endtask
endmodule // host_port_model

// File: tb_char_lcd_instruction_decoder.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_char_lcd_instruction_decoder
   import char_lcd_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       xfer, sel, rd, busy, bus8, blink;
   logic [7:0] din, dout, dchar, grow, q;
   logic [6:0] daddr = 7'h00;
   logic [6:0] cur_o, pan_o;
   logic [5:0] gaddr = 6'h00;
   logic [3:0] crow;
   disp_cfg_t  cfg_o;
   disp_cfg_t  mcfg = '0;
   int         failures = 0;
   int         comparisons = 0;
   integer     seed = 32'h6d98baa2;
   int         cur = 0, inc = 1, scr = 0, pan = 0, gl = 0, lok = 0;
   int         cram[128];
   int         gram[64];
   always #2 clk = ~clk;
   char_lcd_instruction_decoder #(.SHORT_CYC(4), .LONG_CYC(200), .BLINK_CYC(8)) dut (
      .core_clk_i(clk), .rst_i(rst), .xfer_i(xfer), .cmd_data_select_i(sel), .read_i(rd),
      .bus_data_i(din), .disp_addr_i(daddr), .glyph_addr_i(gaddr), .bus_data_o(dout),
      .busy_flag_o(busy), .bus_width_select_o(bus8), .disp_cfg_o(cfg_o),
      .disp_shift_o(pan_o), .cursor_addr_o(cur_o), .cursor_row_o(crow),
      .blink_phase_o(blink), .disp_char_o(dchar), .glyph_row_o(grow));
   host_port_model host (.core_clk_i(clk), .rd_data_i(dout), .xfer_o(xfer),
      .cmd_data_select_o(sel), .read_o(rd), .bus_data_o(din));
   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   function automatic int lim();
      return mcfg.two_line ? 39 : 79;
   endfunction
   function automatic int mv(int left);
      return left ? (pan == lim() ? 0 : pan + 1) : (pan == 0 ? lim() : pan - 1);
   endfunction
   function automatic int stepa(int a, int d);
      if (gl) return (a + (d ? 63 : 1)) % 64;
      if (!mcfg.two_line) return d ? (a == 0 ? 79 : a - 1) : (a == 79 ? 0 : a + 1);
      if (d) return a == 0 ? 103 : (a == 64 ? 39 : a - 1);
      return a == 39 ? 64 : (a == 103 ? 0 : a + 1);
   endfunction
   task automatic chk();
      host.ready();
      host.put(1'b0, 1'b1, 8'h00, q);
      cmp(q, {1'b0, 7'(cur)});
      cmp({1'b0, pan_o}, 8'(pan));
      cmp({3'b000, cfg_o}, {3'b000, mcfg});
      cmp({7'h00, bus8}, {7'h00, !host.narrow});
   endtask
   task automatic cmd(input logic [7:0] d);
      host.send(1'b0, d);
      if (d == 8'h01) begin
         foreach (cram[i]) cram[i] = 32;
         inc = 1;
      end
      if (d[7:2] == 6'h00) begin
         cur = 0;
         pan = 0;
         gl = 0;
         lok = 0;
      end else if (d[7:2] == 6'h01) begin
         inc = d[1];
         scr = d[0];
      end else if (d[7:3] == 5'h01) mcfg[4:2] = d[2:0];
      else if (d[7:4] == 4'h1) begin
         if (d[3]) pan = mv(!d[2]);
         else cur = stepa(cur, !d[2]);
         lok = lok | !d[3];
      end else if (d[7:5] == 3'h1) begin
         mcfg[1:0] = d[3:2];
         host.narrow = !d[4];
      end else begin
         gl = !d[7];
         cur = d[7] ? d[6:0] : d[5:0];
         lok = 1;
      end
      chk();
   endtask
   task automatic wr(input logic [7:0] d, input logic extra);
      host.send(1'b1, d);
      if (extra) host.put(1'b1, 1'b0, ~d, q);
      if (gl) gram[cur] = d;
      else cram[cur] = d;
      if (scr && !gl) pan = mv(inc);
      cur = stepa(cur, !inc);
      lok = 0;
      chk();
   endtask
   task automatic rdv();
      host.get(1'b1, q);
      if (lok) cmp(q, 8'(gl ? gram[cur] : cram[cur]));
      cur = stepa(cur, !inc);
      lok = 1;
      chk();
   endtask
   task automatic see(input int a);
      @(negedge clk);
      daddr = 7'(a);
      gaddr = 6'(a);
      @(negedge clk);
      cmp(dchar, 8'(cram[a]));
      cmp(grow, 8'(gram[a % 64]));
   endtask
   function automatic logic [7:0] rnd();
      return 8'($random(seed)) | 8'h01;
   endfunction
   initial begin
      #300000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      cmp(dout, 8'h00);
      cmp({busy, cur_o}, 8'h00);
      cmp({2'b00, bus8, cfg_o}, 8'h20);
      cmd(8'h38);
      cmd(8'h04);
      cmd(8'h01);
      cmd(8'h07);
      cmd(8'h40);
      for (int i = 0; i < 64; i++) wr(rnd(), 1'b0);
      for (int i = 0; i < 10; i++) see($random(seed) & 127);
      cmd(8'h0f);
      repeat (30) @(negedge clk);
      cmd(8'h3c);
      cmd(8'h38);
      cmd(8'ha6);
      for (int i = 0; i < 4; i++) wr(rnd(), i == 1);
      cmd(8'h04);
      cmd(8'hc1);
      for (int i = 0; i < 5; i++) rdv();
      wr(rnd(), 1'b0);
      rdv();
      rdv();
      for (int k = 0; k < 4; k++) cmd(8'h10 | 8'(k << 2));
      rdv();
      cmd(8'h08);
      cmd(8'h0c);
      see(8'h40);
      cmd(8'h02);
      see(8'h41);
      host.put(1'b0, 1'b0, 8'h00, q);
      cmp({7'h00, busy}, 8'h00);
      chk();
      cmd(8'h05);
      wr(rnd(), 1'b0);
      cmd(8'h30);
      cmd(8'h06);
      cmd(8'hcf);
      wr(rnd(), 1'b0);
      cmd(8'h28);
      cmd(8'h90);
      for (int i = 0; i < 3; i++) wr(rnd(), 1'b0);
      cmd(8'h90);
      for (int i = 0; i < 3; i++) rdv();
      stop_test();
   end
endmodule // tb_char_lcd_instruction_decoder
bind char_lcd_instruction_decoder char_lcd_instruction_decoder_properties #(
   .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC), .BLINK_CYC(BLINK_CYC)) chk_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .xfer_i(xfer_i),
   .cmd_data_select_i(cmd_data_select_i), .read_i(read_i), .bus_data_i(bus_data_i),
   .bus_data_o(bus_data_o), .busy_flag_o(busy_flag_o),
   .bus_width_select_o(bus_width_select_o), .disp_cfg_o(disp_cfg_o),
   .disp_shift_o(disp_shift_o), .cursor_addr_o(cursor_addr_o),
   .cursor_row_o(cursor_row_o), .blink_phase_o(blink_phase_o));
